// >>> audio_source.sv
// Behavioural audio source driving the bit clock, word clock and lanes
`timescale 1ns/1ns

// ****************************************************************
// Audio source model
// ****************************************************************
module audio_source (
	// Control from the bench
	input  wire logic       run_in,
	input  wire logic [3:0] left_in,
	input  wire logic [3:0] right_in,
	// Link pins
	output logic            bit_clock_out,
	output logic            word_clock_out,
	output logic [3:0]      lane_out
);
	// Two bit clocks per frame keep the 1024-frame waits short; the word
	// clock is high for exactly one bit clock
	initial begin
		bit_clock_out = 1'b0;
		word_clock_out = 1'b0;
		lane_out = 4'h0;
		#1;
		forever begin
			if (run_in) begin
				word_clock_out = 1'b1;
				lane_out = left_in;
				#24 bit_clock_out = 1'b1;
				#24 bit_clock_out = 1'b0;
				word_clock_out = 1'b0;
				lane_out = right_in;
				#24 bit_clock_out = 1'b1;
				#24 bit_clock_out = 1'b0;
			end else begin
				// Released lanes toggle while the clock stands still
				lane_out = ~lane_out;
				#48;
			end
		end
	end
endmodule

// >>> dac_ctrl_pkg.sv
// Shared constants, types and decoders for the converter control block
package dac_ctrl_pkg;
	// ****************************************************************
	// Power-on and zero detection counts
	// ****************************************************************
	localparam int POR_CYCLES     = 65536;
	localparam int ZERO_PERIODS   = 1024;
	localparam int ZCNT_W         = 11;
	localparam int NCH            = 8;
	localparam int FIFO_DEPTH     = 8;
	// ****************************************************************
	// System clock ratio codes and oversampling rates
	// ****************************************************************
	localparam logic [2:0] RATIO_128  = 3'h0;
	localparam logic [2:0] RATIO_192  = 3'h1;
	localparam logic [2:0] RATIO_256  = 3'h2;
	localparam logic [2:0] RATIO_384  = 3'h3;
	// Codes 4 to 6 stand for 512, 768 and 1152
	localparam logic [7:0] OS_16  = 8'h10;
	localparam logic [7:0] OS_32  = 8'h20;
	localparam logic [7:0] OS_64  = 8'h40;
	localparam logic [7:0] OS_128 = 8'h80;
	// ****************************************************************
	// Audio format codes driven out
	// ****************************************************************
	localparam logic [3:0] FMT_RJ24   = 4'h0;
	localparam logic [3:0] FMT_I2S    = 4'h4;
	localparam logic [3:0] FMT_LJ     = 4'h5;
	localparam logic [3:0] FMT_TDM24  = 4'h8;
	localparam logic [1:0] DEEMPH_441 = 2'h1;
	// Interface select pin: {level, weakly driven}
	localparam logic [1:0] SEL_TIED_LOW  = 2'h0;
	localparam logic [1:0] SEL_WEAK_LOW  = 2'h1;
	localparam logic [1:0] SEL_TIED_HIGH = 2'h2;
	localparam logic [1:0] SEL_WEAK_HIGH = 2'h3;

	typedef enum logic [1:0] {
		MODE_TWO_WIRE, MODE_PIN_NARROW, MODE_PIN_WIDE, MODE_THREE_WIRE
	} if_mode_e;

	// Settings from the serial register file
	typedef struct packed {
		logic       wide;
		logic [1:0] zero_combo_select;
		logic       zero_polarity_invert;
		logic       mute;
		logic [1:0] deemph;
		logic [3:0] format;
	} reg_set_s;

	// Settings applied to the datapath
	typedef struct packed {
		logic       mute;
		logic [1:0] deemph;
		logic [3:0] format;
	} applied_s;

	// Channel masks, bit = lane*2 + (0 left, 1 right)
	function automatic logic [15:0] zero_masks(input logic [1:0] c);
		case (c)
			2'h0:    zero_masks = {8'h01, 8'h02};
			2'h1:    zero_masks = {8'hFF, 8'hFF};
			2'h2:    zero_masks = {8'hC0, 8'h3F};
			default: zero_masks = {8'h03, 8'hFC};
		endcase
	endfunction

	function automatic logic [7:0] os_rate(input logic [2:0] r,
		input logic wide);
		logic [7:0] n;
		n = (r <= RATIO_192) ? OS_16 : (r <= RATIO_384) ? OS_32 : OS_64;
		os_rate = wide ? {n[6:0], 1'b0} : n;
	endfunction
endpackage

// >>> dac_mode_zero_flag_control.sv
// Mode select, oversampling and zero-flag control with its sample FIFO
// Summary of operation
// - Word clock and four lanes sampled on bit clock rising edge.
// - De-emphasis offered for 32, 44.1 and 48 kHz rates.
// - Wide mode from select pin in pin mode, else register bit.
// - Narrow: 16x at 128/192, 32x at 256/384, 64x above.
// - Wide: every narrow rate doubled.
// - Two-bit combination setting picks flag channel grouping.
// - Combinations A to D map channels onto the two flags.
// - Flag asserts after 1024 all-zero word-clock periods.
// - Flag drops at once on any one bit of its channels.
// - Polarity invert bit flips flag level, resets active high.
// - Pin mode: flag one pin is format input, flag two all eight.
// - Select pin four states decode to the four interface modes.
// - Select pin sampled once at power-on, later changes ignored.
// - Four shared pins reassigned by interface mode.
// - Serial mode uses register settings, pin mode uses pins.
// - Pin format inputs decode to RJ24, I2S, LJ, TDM24.
// - Mute pin soft-mutes all channels in pin mode.
// - De-emphasis pin enables 44.1 kHz de-emphasis in pin mode.
// - Initialization held 65,536 clocks on defaults, then settings applied.
`timescale 1ns/1ns

// ********************************************************************
// Synchronous FIFO
// ********************************************************************
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	output logic      [WIDTH-1:0] rd_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_reg;
	logic [AW-1:0]    rp_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign wr_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign rd_valid = (cnt_reg != '0);
	assign rd_data  = mem[rp_reg];
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_valid && rd_ready;

	// Storage has no reset; only pointers and fill level need a defined state
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= wr_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	chk_fifo_no_overflow:
		assert property (@(posedge clk) disable iff (!arst_n)
			cnt_reg <= (AW+1)'(DEPTH))
		else $error("fifo level above depth");
endmodule

// ********************************************************************
// Top level
// ********************************************************************
module dac_mode_zero_flag_control
	import dac_ctrl_pkg::*;
#(
	parameter int POR_CLOCKS = dac_ctrl_pkg::POR_CYCLES
) (
	// Clock and reset
	input  wire logic                    CLK_IN,
	input  wire logic                    ARST_N_IN,
	// Pins: select, audio link, shared control pins
	input  wire logic [1:0]              INTERFACE_SELECT_PIN_IN,
	input  wire logic                    BIT_CLOCK_IN,
	input  wire logic                    WORD_CLOCK_IN,
	input  wire logic [3:0]              AUDIO_IN_LANE_IN,
	input  wire logic                    SHARED_PIN4_IN,
	input  wire logic                    SHARED_PIN3_IN,
	input  wire logic                    SHARED_PIN2_IN,
	input  wire logic                    ZERO_FLAG_ONE_IN,
	output logic                         ZERO_FLAG_ONE_OUT,
	output logic                         ZERO_FLAG_ONE_OE_N_OUT,
	output logic                         ZERO_FLAG_TWO_OUT,
	// Settings from the serial register file
	input  wire dac_ctrl_pkg::reg_set_s  REG_SET_IN,
	input  wire logic [2:0]              CLK_RATIO_IN,
	// Control port pins routed to the serial decoder
	output logic                         CTRL_SERIAL_IN_OUT,
	output logic                         CTRL_SHIFT_CLOCK_OUT,
	output logic                         CTRL_SELECT_N_OUT,
	output logic                         ADDR_SELECT_OUT,
	// Status and applied settings
	output dac_ctrl_pkg::if_mode_e       MODE_OUT,
	output logic                         INIT_DONE_OUT,
	output dac_ctrl_pkg::applied_s       APPLIED_OUT,
	output logic [7:0]                   OS_RATE_OUT
);
	localparam int SW = 12;
	localparam int PW = $clog2(POR_CLOCKS + 1);

	logic [SW-1:0]    sync_a_reg;
	logic [SW-1:0]    sync_b_reg;
	logic             bck_d_reg;
	logic             wck_d_reg;
	logic [PW-1:0]    por_reg;
	logic             init_done;
	logic             sel_taken_reg;
	if_mode_e         mode_reg;
	logic             pin_mode;
	logic             bck_rise;
	logic             wck_s;
	logic [3:0]       lane_s;
	logic             left_high;
	logic [NCH-1:0]   live_one;
	logic [NCH-1:0]   acc_reg;
	logic [NCH-1:0]   pend_reg;
	logic             pend_valid_reg;
	logic             fifo_ready;
	logic [NCH-1:0]   fifo_data;
	logic             fifo_valid;
	logic             drain;
	logic [15:0]      masks;
	logic [ZCNT_W-1:0] zcnt_reg [2];
	logic [1:0]       zflag;
	logic             inv;
	logic             fmt_hi_s;
	logic             fmt_lo_s;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// All pins are asynchronous to the system clock; two flops each
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sync_a_reg <= '0;
			sync_b_reg <= '0;
		end else begin
			sync_a_reg <= {INTERFACE_SELECT_PIN_IN, BIT_CLOCK_IN,
				WORD_CLOCK_IN, AUDIO_IN_LANE_IN, SHARED_PIN4_IN,
				SHARED_PIN3_IN, SHARED_PIN2_IN, ZERO_FLAG_ONE_IN};
			sync_b_reg <= sync_a_reg;
		end
	end

	assign bck_rise = sync_b_reg[9] && !bck_d_reg;
	assign wck_s    = sync_b_reg[8];
	assign lane_s   = sync_b_reg[7:4];
	assign fmt_hi_s = sync_b_reg[0 + 1];
	assign fmt_lo_s = sync_b_reg[0];

	// ****************************************************************
	// Power-on hold and select capture
	// ****************************************************************
	assign init_done = (por_reg == PW'(POR_CLOCKS));

	// Hold counter; nothing is applied until it runs out
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			por_reg <= '0;
		end else if (!init_done) begin
			por_reg <= por_reg + 1'b1;
		end
	end

	// Select pin taken once after synchronisers settle, then frozen
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sel_taken_reg <= 1'b0;
			mode_reg      <= MODE_TWO_WIRE;
		end else if (!sel_taken_reg && por_reg == PW'(3)) begin
			sel_taken_reg <= 1'b1;
			case (sync_b_reg[11:10])
				SEL_TIED_LOW:  mode_reg <= MODE_TWO_WIRE;
				SEL_WEAK_LOW:  mode_reg <= MODE_PIN_NARROW;
				SEL_WEAK_HIGH: mode_reg <= MODE_PIN_WIDE;
				SEL_TIED_HIGH: mode_reg <= MODE_THREE_WIRE;
				default:       mode_reg <= MODE_TWO_WIRE;
			endcase
		end
	end

	assign pin_mode = (mode_reg == MODE_PIN_NARROW) ||
		(mode_reg == MODE_PIN_WIDE);

	// ****************************************************************
	// Audio sampling and per-period zero tracking
	// ****************************************************************
	// I2S-style formats put the left channel in the low half
	assign left_high = pin_mode ? !fmt_lo_s :
		(REG_SET_IN.format != FMT_I2S) && (REG_SET_IN.format != FMT_TDM24);

	// One bit seen on a channel in this bit-clock edge
	generate
		for (genvar l = 0; l < 4; l++) begin : g_lane
			assign live_one[2*l]   = bck_rise && lane_s[l] &&
				(wck_s == left_high);
			assign live_one[2*l+1] = bck_rise && lane_s[l] &&
				(wck_s != left_high);
		end
	endgenerate

	// Edge history of the sampled clocks
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			bck_d_reg <= 1'b0;
			wck_d_reg <= 1'b0;
		end else begin
			bck_d_reg <= sync_b_reg[9];
			if (bck_rise) begin
				wck_d_reg <= wck_s;
			end
		end
	end

	// Period ends on a word-clock rise seen at a bit-clock edge.
	// If the FIFO is full the finished period waits in the pending
	// word and later periods merge into it, so nothing is lost.
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			acc_reg        <= '0;
			pend_reg       <= '0;
			pend_valid_reg <= 1'b0;
		end else begin
			if (pend_valid_reg && fifo_ready) begin
				pend_valid_reg <= 1'b0;
			end
			if (bck_rise && wck_s && !wck_d_reg) begin
				acc_reg        <= live_one;
				pend_valid_reg <= 1'b1;
				pend_reg       <= (pend_valid_reg && !fifo_ready) ?
					(pend_reg | acc_reg) : acc_reg;
			end else begin
				acc_reg <= acc_reg | live_one;
			end
		end
	end

	// Draining stalls during the power-on hold
	assign drain = init_done;

	sample_fifo #(
		.WIDTH(NCH),
		.DEPTH(FIFO_DEPTH)
	) sample_fifo_inst (
		.clk     (CLK_IN),
		.arst_n  (ARST_N_IN),
		.wr_data (pend_reg),
		.wr_valid(pend_valid_reg),
		.wr_ready(fifo_ready),
		.rd_data (fifo_data),
		.rd_valid(fifo_valid),
		.rd_ready(drain)
	);

	// ****************************************************************
	// Zero-run counters
	// ****************************************************************
	// Pin mode fixes flag two on all channels
	assign masks = pin_mode ? {8'h00, 8'hFF} :
		zero_masks(REG_SET_IN.zero_combo_select);

	generate
		for (genvar f = 0; f < 2; f++) begin : g_flag
			// Live one bits clear at once; drained periods count
			always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
				if (!ARST_N_IN) begin
					zcnt_reg[f] <= '0;
				end else if (|(live_one & masks[8*(1-f) +: 8])) begin
					zcnt_reg[f] <= '0;
				end else if (fifo_valid && drain) begin
					if (|(fifo_data & masks[8*(1-f) +: 8])) begin
						zcnt_reg[f] <= '0;
					end else if (zcnt_reg[f] != ZCNT_W'(ZERO_PERIODS)) begin
						zcnt_reg[f] <= zcnt_reg[f] + 1'b1;
					end
				end
			end
			assign zflag[f] = (zcnt_reg[f] == ZCNT_W'(ZERO_PERIODS));
		end
	endgenerate

	assign inv = !pin_mode && REG_SET_IN.zero_polarity_invert;

	// ****************************************************************
	// Outputs and pin reassignment
	// ****************************************************************
	// Flag defaults hold until the power-on hold ends; mode follows the capture
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ZERO_FLAG_ONE_OUT      <= 1'b0;
			ZERO_FLAG_ONE_OE_N_OUT <= 1'b1;
			ZERO_FLAG_TWO_OUT      <= 1'b0;
			INIT_DONE_OUT          <= 1'b0;
			MODE_OUT               <= MODE_TWO_WIRE;
		end else begin
			INIT_DONE_OUT     <= init_done;
			MODE_OUT          <= mode_reg;
			ZERO_FLAG_ONE_OUT <= init_done && !pin_mode &&
				(zflag[0] ^ inv);
			ZERO_FLAG_TWO_OUT <= init_done && (zflag[1] ^ inv);
			// Flag one pin becomes an input in pin mode
			ZERO_FLAG_ONE_OE_N_OUT <= !init_done || pin_mode;
		end
	end

	// Control port passthrough is idle in pin mode
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			CTRL_SERIAL_IN_OUT   <= 1'b1;
			CTRL_SHIFT_CLOCK_OUT <= 1'b0;
			CTRL_SELECT_N_OUT    <= 1'b1;
			ADDR_SELECT_OUT      <= 1'b0;
		end else begin
			CTRL_SERIAL_IN_OUT   <= pin_mode || sync_b_reg[3];
			CTRL_SHIFT_CLOCK_OUT <= !pin_mode && sync_b_reg[2];
			CTRL_SELECT_N_OUT    <= pin_mode || !init_done ||
				sync_b_reg[1] || mode_reg == MODE_TWO_WIRE;
			ADDR_SELECT_OUT      <= (mode_reg == MODE_TWO_WIRE) &&
				sync_b_reg[1];
		end
	end

	// Applied settings: pins in pin mode, registers otherwise
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			APPLIED_OUT <= '{mute: 1'b0, deemph: 2'h0, format: FMT_LJ};
			OS_RATE_OUT <= OS_16;
		end else if (init_done && pin_mode) begin
			APPLIED_OUT.mute   <= sync_b_reg[3];
			APPLIED_OUT.deemph <= sync_b_reg[2] ? DEEMPH_441 : 2'h0;
			case ({fmt_hi_s, fmt_lo_s})
				2'h0:    APPLIED_OUT.format <= FMT_RJ24;
				2'h1:    APPLIED_OUT.format <= FMT_I2S;
				2'h2:    APPLIED_OUT.format <= FMT_LJ;
				default: APPLIED_OUT.format <= FMT_TDM24;
			endcase
			OS_RATE_OUT <= os_rate(CLK_RATIO_IN,
				mode_reg == MODE_PIN_WIDE);
		end else if (init_done) begin
			// Rate selects 32, 44.1 or 48 kHz curves downstream
			APPLIED_OUT.mute   <= REG_SET_IN.mute;
			APPLIED_OUT.deemph <= REG_SET_IN.deemph;
			APPLIED_OUT.format <= REG_SET_IN.format;
			OS_RATE_OUT <= os_rate(CLK_RATIO_IN, REG_SET_IN.wide);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_init_hold_flags:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			!INIT_DONE_OUT |-> !ZERO_FLAG_TWO_OUT && !APPLIED_OUT.mute)
		else $error("flag or mute before init end");
	chk_mode_frozen:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			sel_taken_reg |=> $stable(mode_reg))
		else $error("interface mode changed after capture");
	chk_zero_assert:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			zcnt_reg[1] == ZCNT_W'(ZERO_PERIODS) && init_done &&
			!inv |=> ZERO_FLAG_TWO_OUT)
		else $error("flag two missing after zero run");
	chk_zero_clear:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			|(live_one & masks[7:0]) |=> zcnt_reg[1] == '0 ##1
			(ZERO_FLAG_TWO_OUT == $past(init_done && inv)))
		else $error("flag two not dropped on one bit");
	chk_counter_sat:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			zcnt_reg[0] <= ZCNT_W'(ZERO_PERIODS))
		else $error("zero counter past threshold");
	chk_pin_flag_one:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			pin_mode && init_done |=> ZERO_FLAG_ONE_OE_N_OUT &&
			!ZERO_FLAG_ONE_OUT)
		else $error("flag one driven in pin mode");
	chk_wide_rate:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			init_done && mode_reg == MODE_PIN_WIDE &&
			CLK_RATIO_IN == RATIO_128 |=> OS_RATE_OUT == OS_32)
		else $error("wide rate not doubled");
	chk_narrow_rate:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			init_done && mode_reg == MODE_PIN_NARROW &&
			CLK_RATIO_IN > RATIO_384 |=> OS_RATE_OUT == OS_64)
		else $error("narrow rate wrong at high ratio");
	chk_pin_mute:
		assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
			init_done && pin_mode |=>
			APPLIED_OUT.mute == $past(sync_b_reg[3]))
		else $error("mute pin not applied");
endmodule

// >>> dac_mode_zero_flag_control_tb_top.sv
// Self-checking bench for mode select, oversampling and zero flags
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end

module dac_mode_zero_flag_control_tb_top;
	import dac_ctrl_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	localparam int POR = 64;
	logic       clk = 1'b0;
	logic       arst_n, bit_clock, wck, pin4, pin3, pin2, f1_in, run;
	logic       f1_out, f1_oe_n, f2_out, sd, sc, sn, adr, init_done;
	logic [1:0] sel;
	logic [3:0] lanes, left, right;
	logic [2:0] ratio;
	logic [7:0] os;
	reg_set_s   rs;
	applied_s   app;
	if_mode_e   mode;
	int         n_errors, check_count, cyc;
	if_mode_e   modes[4] = '{MODE_TWO_WIRE, MODE_PIN_NARROW,
		MODE_THREE_WIRE, MODE_PIN_WIDE};
	logic [3:0] fmts[4] = '{FMT_RJ24, FMT_I2S, FMT_LJ, FMT_TDM24};

	// Clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 70000) begin
			n_errors++;
			give_verdict();
		end
	end

	audio_source audio_source_inst (.run_in(run), .left_in(left),
		.right_in(right), .bit_clock_out(bit_clock), .word_clock_out(wck),
		.lane_out(lanes));

	dac_mode_zero_flag_control #(.POR_CLOCKS(POR))
		dac_mode_zero_flag_control_inst (
		.CLK_IN(clk), .ARST_N_IN(arst_n), .INTERFACE_SELECT_PIN_IN(sel),
		.BIT_CLOCK_IN(bit_clock), .WORD_CLOCK_IN(wck), .AUDIO_IN_LANE_IN(lanes),
		.SHARED_PIN4_IN(pin4), .SHARED_PIN3_IN(pin3),
		.SHARED_PIN2_IN(pin2), .ZERO_FLAG_ONE_IN(f1_in),
		.ZERO_FLAG_ONE_OUT(f1_out), .ZERO_FLAG_ONE_OE_N_OUT(f1_oe_n),
		.ZERO_FLAG_TWO_OUT(f2_out), .REG_SET_IN(rs), .CLK_RATIO_IN(ratio),
		.CTRL_SERIAL_IN_OUT(sd), .CTRL_SHIFT_CLOCK_OUT(sc),
		.CTRL_SELECT_N_OUT(sn), .ADDR_SELECT_OUT(adr), .MODE_OUT(mode),
		.INIT_DONE_OUT(init_done), .APPLIED_OUT(app), .OS_RATE_OUT(os));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Whole frames, counted on the word clock rise
	task automatic frames(input int n);
		repeat (n) @(posedge wck);
		@(negedge clk);
	endtask

	// One frame carrying a one bit, then quiet frames for the flags
	task automatic pulse(input logic [3:0] l, input logic [3:0] r);
		left = l;
		right = r;
		// Two frames so one whole frame carries both halves
		frames(2);
		left = 4'h0;
		right = 4'h0;
		frames(2);
		tick(8);
	endtask

	// Reset with a select level held from before release
	task automatic power_on(input logic [1:0] s);
		arst_n = 1'b0;
		sel = s;
		tick(20);
		arst_n = 1'b1;
		tick(POR - 8);
		`CHK(init_done, 1'b0)
		`CHK(f1_oe_n, 1'b1)
		tick(16);
		`CHK(init_done, 1'b1)
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		logic [7:0] exp;
		{arst_n, sel, pin4, pin3, pin2, f1_in, ratio, run} = '0;
		{left, right, n_errors, check_count, cyc} = '0;
		rs = '0;
		rs.format = FMT_LJ;
		power_on(SEL_TIED_LOW);
		`CHK(mode, MODE_TWO_WIRE)
		`CHK(f1_oe_n, 1'b0)
		for (int r = 0; r < 7; r++) begin
			for (int w = 0; w < 2; w++) begin
				ratio = 3'(r);
				rs.wide = w[0];
				tick(3);
				exp = (r < 2) ? 8'h10 : (r < 4) ? 8'h20 : 8'h40;
				exp = w[0] ? {exp[6:0], 1'b0} : exp;
				`CHK(os, exp)
			end
		end
		pin4 = 1'b1;
		pin3 = 1'b1;
		pin2 = 1'b1;
		tick(6);
		`CHK({sd, sc, sn, adr}, 4'hF)
		{pin4, pin3, pin2} = 3'h0;
		$display("test serial modes done");

		// Zero flags: threshold, groupings, clearing and polarity
		rs.zero_combo_select = 2'h1;
		run = 1'b1;
		frames(1000);
		`CHK({f1_out, f2_out}, 2'h0)
		frames(40);
		`CHK({f1_out, f2_out}, 2'h3)
		rs.zero_combo_select = 2'h0;
		tick(4);
		`CHK({f1_out, f2_out}, 2'h3)
		pulse(4'h0, 4'h1);
		`CHK({f1_out, f2_out}, 2'h2)
		rs.zero_combo_select = 2'h3;
		pulse(4'h2, 4'h0);
		`CHK({f1_out, f2_out}, 2'h2)
		rs.zero_combo_select = 2'h2;
		pulse(4'h8, 4'h0);
		`CHK({f1_out, f2_out}, 2'h0)
		rs.zero_polarity_invert = 1'b1;
		tick(4);
		`CHK({f1_out, f2_out}, 2'h3)
		$display("test zero flags done");

		// Every select level, captured only at power-on
		rs.mute = 1'b1;
		for (int s = 0; s < 4; s++) begin
			power_on(2'(s));
			`CHK(mode, modes[s])
			if (s == 2) begin
				`CHK({sn, adr}, 2'h0)
				`CHK(app.mute, 1'b1)
			end
		end
		sel = SEL_TIED_LOW;
		tick(10);
		`CHK(mode, MODE_PIN_WIDE)
		ratio = 3'h2;
		rs.wide = 1'b0;
		tick(6);
		`CHK(os, 8'h40)
		ratio = 3'h0;
		tick(6);
		`CHK(os, 8'h20)
		for (int f = 0; f < 4; f++) begin
			{pin2, f1_in} = 2'(f);
			tick(6);
			`CHK(app.format, fmts[f])
		end
		// Back to a two-channel format; the source has no TDM framing
		{pin2, f1_in} = 2'h2;
		{pin4, pin3} = 2'h3;
		tick(6);
		`CHK({app.mute, app.deemph}, {1'b1, DEEMPH_441})
		`CHK({f1_out, f1_oe_n, sd, sc, sn, adr}, 6'h1A)
		{pin4, pin3} = 2'h0;
		tick(6);
		`CHK({app.mute, app.deemph}, 3'h0)
		// Register invert is ignored here; flag two watches all eight
		frames(1040);
		tick(8);
		`CHK({f1_out, f2_out}, 2'h1)
		pulse(4'h4, 4'h0);
		`CHK({f1_out, f2_out}, 2'h0)
		$display("test pin control done");
		give_verdict();
	end
endmodule
